// file: inc/srx_cfg.svh
// Register offsets, field positions, reset values and counts of the receiver.
`ifndef SRX_CFG_SVH
`define SRX_CFG_SVH
// ==========================================================================
// Register indices; the byte address is four times the index.
`define SRX_IDX_LOCK 16'hF600
`define SRX_IDX_CTRL 16'hF601
`define SRX_IDX_DECODE 16'hF602
`define SRX_IDX_IRQ_STAT 16'hF610
`define SRX_IDX_IRQ_CLR 16'hF611
`define SRX_IDX_IRQ_EN 16'hF612
// ==========================================================================
// Reset values of the interrupt registers and the saved decode value.
`define SRX_RST_16 16'h0000
`define SRX_RST_IRQ 3'h0
// ==========================================================================
// Field positions.
`define SRX_LOCK_BIT 0
`define SRX_QUICK_BIT 3
`define SRX_HOLD_BIT 2
`define SRX_WSEL_HI 1
`define SRX_WSEL_LO 0
`define SRX_RDET_HI 9
`define SRX_RDET_LO 6
`define SRX_LDET_HI 5
`define SRX_LDET_LO 2
`define SRX_SCHEME_BIT 1
`define SRX_PACKED_BIT 0
// Interrupt status bits: lock gained, lock lost, decoded format changed.
`define SRX_IRQ_GAIN 0
`define SRX_IRQ_LOSS 1
`define SRX_IRQ_FMT 2
// ==========================================================================
// Counts.
`define SRX_LOCK_NORMAL 7'h40
`define SRX_LOCK_QUICK 7'h08
`define SRX_CS_LAST 8'hBF
`define SRX_CS_PACKED 8'h01
`define SRX_CS_WLEN0 8'h20
`define SRX_CS_WLEN3 8'h23
`endif

// file: inc/srx_pkg.sv
// Types shared by the receiver control and status logic.
package srx_pkg;
	// ==================================================================
	// Word size selection codes of the control register.
	typedef enum logic [1:0]
	{
		SRX_W24 = 2'b00,
		SRX_W20 = 2'b01,
		SRX_W16 = 2'b10,
		SRX_WAUTO = 2'b11
	} srx_wsel_t;
	// Bus data phase kinds.
	typedef enum logic [1:0]
	{
		SRX_PH_IDLE = 2'b00,
		SRX_PH_WRITE = 2'b01,
		SRX_PH_READ = 2'b10
	} srx_phase_t;
endpackage

// file: rtl/srx_cs_decode.sv
// Channel status decoder: detected word sizes and audio type.
`include "srx_cfg.svh"
module srx_cs_decode
	import srx_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic sample_stb,
	input wire logic sample_right,
	input wire logic block_start,
	input wire logic cs_bit,
	input wire logic scheme_bit,
	output logic [3:0] left_detected_size,
	output logic [3:0] right_detected_size,
	output logic packed_audio,
	output logic packed_scheme_flag
);
	// ==================================================================
	// One bit counter and capture per channel; index 0 is left.
	logic [3:0] size_q [2];
	logic [1:0] packed_q;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_ch
			logic [7:0] pos_q;
			logic [3:0] wlen_q;
			logic pk_q;
			logic hit;

			// A sample of this channel arrived.
			assign hit = sample_stb && (sample_right == (ch == 1));

			// Walk the status block and catch the fields of interest.
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					pos_q <= 8'h00;
					wlen_q <= 4'h0;
					pk_q <= 1'b0;
					size_q[ch] <= 4'h0;
					packed_q[ch] <= 1'b0;
				end
				else if (hit)
				begin
					if (block_start || pos_q == `SRX_CS_LAST)
						pos_q <= block_start ? 8'h01 : 8'h00;
					else
						pos_q <= pos_q + 8'h01;
					if (pos_q == `SRX_CS_PACKED)
						pk_q <= cs_bit;
					if (pos_q >= `SRX_CS_WLEN0 && pos_q <= `SRX_CS_WLEN3)
						wlen_q <= {cs_bit, wlen_q[3:1]};
					// Publish once the whole block has been seen.
					if (pos_q == `SRX_CS_LAST)
					begin
						size_q[ch] <= wlen_q;
						packed_q[ch] <= pk_q;
					end
				end
			end
		end
	endgenerate

	// Register the published values; the scheme follows the left block.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			left_detected_size <= 4'h0;
			right_detected_size <= 4'h0;
			packed_audio <= 1'b0;
			packed_scheme_flag <= 1'b0;
		end
		else
		begin
			left_detected_size <= size_q[0];
			right_detected_size <= size_q[1];
			packed_audio <= packed_q[0];
			if (sample_stb && !sample_right && block_start)
				packed_scheme_flag <= scheme_bit;
		end
	end
endmodule

// file: rtl/srx_lock_det.sv
// Lock acquisition counter of the receiver.
`include "srx_cfg.svh"
module srx_lock_det
	import srx_pkg::*;
#(
	parameter int CNT_W = 7
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic sample_stb,
	input wire logic sample_ok,
	input wire logic quick_acquire_select,
	output logic locked_q,
	output logic gain_q,
	output logic loss_q
);
	// ==================================================================
	// Run length of valid samples and the threshold in force.
	logic [CNT_W-1:0] run_q;
	logic [CNT_W-1:0] need;

	// Quick mode needs eight samples, normal mode sixty-four.
	assign need = quick_acquire_select ? CNT_W'(`SRX_LOCK_QUICK)
		: CNT_W'(`SRX_LOCK_NORMAL);

	// Count consecutive valid samples; any bad sample restarts the run.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			run_q <= '0;
		else if (sample_stb && !sample_ok)
			run_q <= '0;
		else if (sample_stb && !locked_q && run_q < need)
			run_q <= run_q + CNT_W'(1);
		else if (locked_q)
			run_q <= '0;
	end

	// Lock is declared on the run reaching the threshold and dropped on
	// the first bad sample; one-cycle event pulses mark both moments.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			locked_q <= 1'b0;
			gain_q <= 1'b0;
			loss_q <= 1'b0;
		end
		else
		begin
			gain_q <= 1'b0;
			loss_q <= 1'b0;
			if (locked_q && sample_stb && !sample_ok)
			begin
				locked_q <= 1'b0;
				loss_q <= 1'b1;
			end
			else if (!locked_q && run_q >= need)
			begin
				locked_q <= 1'b1;
				gain_q <= 1'b1;
			end
		end
	end
endmodule

// file: rtl/srx_top.sv
// Control and status registers of the digital audio receiver.
// ==========================================================================
`include "srx_cfg.svh"
module srx_top
	import srx_pkg::*;
#(
	parameter int LOCK_CNT_W = 7
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic rx_sample_stb,
	input wire logic rx_sample_ok,
	input wire logic rx_sample_right,
	input wire logic rx_block_start,
	input wire logic rx_cs_bit,
	input wire logic rx_scheme_bit,
	input wire logic [23:0] rx_audio,
	input wire logic rx_frame_clk,
	output logic [23:0] audio_out,
	output logic audio_out_stb,
	output logic audio_out_right,
	output logic frame_clk_out,
	output logic irq
);
	// ==================================================================
	// Bus phase tracking.
	srx_phase_t phase_q;
	logic [15:0] idx_q;
	logic take;
	logic [15:0] req_idx;

	// Control register fields.
	logic quick_acquire_select;
	logic frame_clock_hold_policy;
	srx_wsel_t word_size_select;

	// Lock and decode results.
	logic locked;
	logic gain_ev;
	logic loss_ev;
	logic [3:0] left_detected_size;
	logic [3:0] right_detected_size;
	logic packed_audio;
	logic packed_scheme_flag;
	logic [15:0] decode_val;
	logic [15:0] decode_prev_q;

	// Interrupt registers.
	logic [2:0] irq_stat_q;
	logic [2:0] irq_en_q;
	logic [2:0] irq_set;
	logic [2:0] irq_clr;

	// Audio path.
	logic [4:0] eff_len;
	logic [23:0] keep_mask;

	// ==================================================================
	// Bus slave.
	// A transfer is taken when selected, active and the bus is ready.
	assign take = hsel && htrans[1] && hready && hreadyout;
	assign req_idx = haddr[17:2];

	// Capture the address phase; reads insert one wait cycle so that a
	// write just before them is already visible.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			phase_q <= SRX_PH_IDLE;
			idx_q <= 16'h0000;
			hreadyout <= 1'b1;
		end
		else if (take)
		begin
			// Bits above the index or a misaligned address never match.
			if (haddr[31:18] != 14'h0000 || haddr[1:0] != 2'b00)
				idx_q <= 16'h0000;
			else
				idx_q <= req_idx;
			phase_q <= hwrite ? SRX_PH_WRITE : SRX_PH_READ;
			hreadyout <= hwrite;
		end
		else if (phase_q == SRX_PH_READ)
		begin
			phase_q <= SRX_PH_IDLE;
			hreadyout <= 1'b1;
		end
		else
		begin
			phase_q <= SRX_PH_IDLE;
			hreadyout <= 1'b1;
		end
	end

	// The response is always OKAY.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	// Read data come from a register loaded during the wait cycle.
	// Unmapped addresses and the write-only clear register read zero.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (phase_q == SRX_PH_READ && !hreadyout)
		begin
			hrdata <= 32'h0000_0000;
			if (idx_q == `SRX_IDX_LOCK)
				hrdata[`SRX_LOCK_BIT] <= locked;
			else if (idx_q == `SRX_IDX_CTRL)
			begin
				hrdata[`SRX_QUICK_BIT] <= quick_acquire_select;
				hrdata[`SRX_HOLD_BIT] <= frame_clock_hold_policy;
				hrdata[`SRX_WSEL_HI:`SRX_WSEL_LO] <= word_size_select;
			end
			else if (idx_q == `SRX_IDX_DECODE)
				hrdata[15:0] <= decode_val;
			else if (idx_q == `SRX_IDX_IRQ_STAT)
				hrdata[2:0] <= irq_stat_q;
			else if (idx_q == `SRX_IDX_IRQ_EN)
				hrdata[2:0] <= irq_en_q;
		end
	end

	// ==================================================================
	// Control register; the reserved bits are not stored and read zero.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			// Normal lock, strong output and 24-bit words after reset.
			quick_acquire_select <= 1'b0;
			frame_clock_hold_policy <= 1'b0;
			word_size_select <= SRX_W24;
		end
		else if (phase_q == SRX_PH_WRITE && idx_q == `SRX_IDX_CTRL)
		begin
			quick_acquire_select <= hwdata[`SRX_QUICK_BIT];
			frame_clock_hold_policy <= hwdata[`SRX_HOLD_BIT];
			word_size_select <=
				srx_wsel_t'(hwdata[`SRX_WSEL_HI:`SRX_WSEL_LO]);
		end
	end

	// ==================================================================
	// Lock detection and channel status decode.
	srx_lock_det #(
		.CNT_W(LOCK_CNT_W)
	) u_lock (
		.hclk(hclk),
		.hresetn(hresetn),
		.sample_stb(rx_sample_stb),
		.sample_ok(rx_sample_ok),
		.quick_acquire_select(quick_acquire_select),
		.locked_q(locked),
		.gain_q(gain_ev),
		.loss_q(loss_ev)
	);

	srx_cs_decode u_dec (
		.hclk(hclk),
		.hresetn(hresetn),
		.sample_stb(rx_sample_stb),
		.sample_right(rx_sample_right),
		.block_start(rx_block_start),
		.cs_bit(rx_cs_bit),
		.scheme_bit(rx_scheme_bit),
		.left_detected_size(left_detected_size),
		.right_detected_size(right_detected_size),
		.packed_audio(packed_audio),
		.packed_scheme_flag(packed_scheme_flag)
	);

	// Decode register layout; the reserved upper bits read zero.
	assign decode_val = {6'h00, right_detected_size,
		left_detected_size, packed_scheme_flag, packed_audio};

	// ==================================================================
	// Interrupts.
	// Keep the previous decode value to see a change of format.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			decode_prev_q <= `SRX_RST_16;
		else
			decode_prev_q <= decode_val;
	end

	// Events and the clear strobe of a write to the clear register.
	always_comb
	begin
		irq_set = 3'h0;
		irq_set[`SRX_IRQ_GAIN] = gain_ev;
		irq_set[`SRX_IRQ_LOSS] = loss_ev;
		irq_set[`SRX_IRQ_FMT] = decode_val != decode_prev_q;
		irq_clr = 3'h0;
		if (phase_q == SRX_PH_WRITE && idx_q == `SRX_IDX_IRQ_CLR)
			irq_clr = hwdata[2:0];
	end

	// Sticky status: a new event wins over a clear in the same cycle.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_stat_q <= `SRX_RST_IRQ;
		else
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
	end

	// Enable register.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_en_q <= `SRX_RST_IRQ;
		else if (phase_q == SRX_PH_WRITE && idx_q == `SRX_IDX_IRQ_EN)
			irq_en_q <= hwdata[2:0];
	end

	// Level interrupt while any enabled status bit is set.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq <= 1'b0;
		else
			irq <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
	end

	// ==================================================================
	// Audio path.
	// Effective word length; automatic mode follows the left channel
	// code, whose low bit tells a 24-bit maximum from a 20-bit one.
	always_comb
	begin
		eff_len = 5'd24;
		unique case (word_size_select)
			SRX_W24: eff_len = 5'd24;
			SRX_W20: eff_len = 5'd20;
			SRX_W16: eff_len = 5'd16;
			SRX_WAUTO:
			begin
				unique case (left_detected_size[3:1])
					3'b001: eff_len = left_detected_size[0] ? 5'd20 : 5'd16;
					3'b110: eff_len = left_detected_size[0] ? 5'd21 : 5'd17;
					3'b010: eff_len = left_detected_size[0] ? 5'd22 : 5'd18;
					3'b100: eff_len = left_detected_size[0] ? 5'd23 : 5'd19;
					3'b101: eff_len = left_detected_size[0] ? 5'd24 : 5'd20;
					default: eff_len = 5'd24;
				endcase
			end
		endcase
		keep_mask = ~(24'hFFFFFF >> eff_len);
	end

	// Audio words pass truncated to the chosen length and are muted
	// whenever lock is missing.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			audio_out <= 24'h000000;
			audio_out_stb <= 1'b0;
			audio_out_right <= 1'b0;
		end
		else
		begin
			audio_out_stb <= rx_sample_stb;
			audio_out_right <= rx_sample_right;
			if (rx_sample_stb)
			begin
				if (locked && !(rx_sample_ok == 1'b0))
					audio_out <= rx_audio & keep_mask;
				else
					audio_out <= 24'h000000;
			end
		end
	end

	// Frame clock: strong policy always passes it on, weak policy stops
	// it at once while lock is missing or the current sample is bad.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			frame_clk_out <= 1'b0;
		else if (!frame_clock_hold_policy)
			frame_clk_out <= rx_frame_clk;
		else if (!locked || (rx_sample_stb && !rx_sample_ok))
			frame_clk_out <= 1'b0;
		else
			frame_clk_out <= rx_frame_clk;
	end
endmodule

// file: verification/srx_src_model.sv
// Behavioural source of the decoded sample stream feeding the receiver.
module srx_src_model
	import srx_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic load,
	input wire logic [15:0] n_smp,
	input wire logic bad,
	input wire logic [3:0] lcode,
	input wire logic [3:0] rcode,
	input wire logic pk,
	input wire logic sch,
	output logic busy,
	output logic stb,
	output logic ok,
	output logic right,
	output logic bstart,
	output logic cs,
	output logic scheme,
	output logic [23:0] aud,
	output logic fclk
);
	// ==================================================================
	// Sample sequencing.
	logic [15:0] remain_q; // Samples still to send.
	logic [8:0] pos_q; // Sample index in the block, left first.
	logic [7:0] fr; // Frame index in the block.
	logic cbit; // Channel status bit of this sample.
	// One sample every second cycle; the frame clock idles between bursts.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			remain_q <= 16'h0;
			stb <= 1'b0;
			pos_q <= 9'h0;
			fclk <= 1'b0;
		end
		else if (load)
			remain_q <= n_smp;
		else if (remain_q != 16'h0)
		begin
			stb <= !stb;
			if (stb)
			begin
				remain_q <= remain_q - 16'h1;
				pos_q <= (pos_q == 9'h17F) ? 9'h0 : pos_q + 9'h1;
				fclk <= fclk ^ pos_q[0];
			end
		end
	end
	assign fr = pos_q[8:1];
	// Bit 1 flags packed audio; bits 32 to 35 carry the size code.
	always_comb
	begin
		cbit = 1'b0;
		if (fr == 8'h01)
			cbit = pk;
		else if (fr >= 8'h20 && fr <= 8'h23)
			cbit = pos_q[0] ? rcode[fr[1:0]] : lcode[fr[1:0]];
	end
	assign busy = load || remain_q != 16'h0;
	// Off the strobe every qualified line shows its inverse.
	assign ok = stb ? !bad : bad;
	assign right = stb ? pos_q[0] : !pos_q[0];
	assign bstart = stb ? pos_q == 9'h0 : pos_q != 9'h0;
	assign cs = stb ? cbit : !cbit;
	assign scheme = stb ? sch : !sch;
	assign aud = stb ? 24'hABCDEF : 24'h543210;
endmodule

// file: verification/srx_sva.sv
// Port-level checker of the receiver control and status block.
module srx_sva
	import srx_pkg::*;
#(
	parameter int LOCK_CNT_W = 7
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic rx_sample_stb,
	input wire logic rx_sample_ok,
	input wire logic rx_sample_right,
	input wire logic [23:0] audio_out,
	input wire logic audio_out_stb,
	input wire logic audio_out_right,
	input wire logic frame_clk_out
);
	// ==================================================================
	// Shadow of the hold policy bit, taken from bus writes.
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic wr_q; // Data phase of a control write is running.
	logic hold_q; // Last hold policy written.
	wire logic take = hsel && htrans[1] && hready && hreadyout;
	// Marks the data phase of a write to the control register.
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			wr_q <= 1'b0;
		else
			wr_q <= take && hwrite && haddr == 32'h0003D804;
	// Takes the policy bit when that data phase completes.
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			hold_q <= 1'b0;
		else if (wr_q && hready)
			hold_q <= hwdata[2];
	// ==================================================================
	// Bus timing.
	read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	write_nowait_a: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	wait_once_a: assert property (!hreadyout |=> hreadyout)
		else $error("wait state too long");
	upper_zero_a: assert property ($rose(hreadyout) |-> hrdata[31:16] == 16'h0)
		else $error("upper read data not zero");
	okay_resp_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	// ==================================================================
	// Audio path.
	out_stb_a: assert property (audio_out_stb == $past(rx_sample_stb))
		else $error("output strobe not one cycle late");
	out_side_a: assert property (audio_out_stb |->
		audio_out_right == $past(rx_sample_right))
		else $error("output channel wrong");
	loss_mute_a:
		assert property (rx_sample_stb && !rx_sample_ok |=> audio_out == 24'h0)
		else $error("audio not muted on loss");
	weak_stop_a:
		assert property (rx_sample_stb && !rx_sample_ok && hold_q |->
		##[1:2] !frame_clk_out)
		else $error("frame clock not stopped");
endmodule
bind srx_top srx_sva #(.LOCK_CNT_W(LOCK_CNT_W)) chk (.hclk, .hresetn,
	.hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout,
	.hresp, .rx_sample_stb, .rx_sample_ok, .rx_sample_right, .audio_out,
	.audio_out_stb, .audio_out_right, .frame_clk_out);

// file: verification/tb_top.sv
// Self-checking bench of the receiver control and status block.
`include "srx_cfg.svh"
`define CHK(a, e) \
	begin \
		checked++; \
		if ((a) !== (e)) \
		begin \
			n_mismatch++; \
			$display("[FAIL] t=%0t got %h exp %h", $time, a, e); \
		end \
	end
module tb_top
	import srx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ==================================================================
	// Signals and tables.
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, load, bad, pk, sch, fc_prev;
	logic [31:0] haddr, hwdata, hrdata, exp_dec;
	logic [1:0] htrans;
	logic [15:0] n_smp;
	logic [3:0] lcode, rcode;
	logic [23:0] audio_out, last_aud, aud;
	logic hreadyout, hresp, irq, busy, audio_out_stb, audio_out_right;
	logic frame_clk_out, stb, ok, right, bstart, cs, scheme, fclk;
	int n_mismatch = 0;
	int checked = 0;
	int n_fc = 0;
	// Size codes; the last one is 16 bits for the automatic case.
	logic [3:0] tbl [10] = '{4'hB, 4'h3, 4'hD, 4'h5, 4'h9, 4'hA, 4'hC,
		4'h4, 4'h8, 4'h2};
	logic [23:0] trunc [4] = '{24'hABCDEF, 24'hABCDE0, 24'hABCD00,
		24'hABCD00};
	srx_top #(.LOCK_CNT_W(7)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .rx_sample_stb(stb), .rx_sample_ok(ok),
		.rx_sample_right(right), .rx_block_start(bstart), .rx_cs_bit(cs),
		.rx_scheme_bit(scheme), .rx_audio(aud), .rx_frame_clk(fclk),
		.audio_out, .audio_out_stb, .audio_out_right, .frame_clk_out, .irq);
	srx_src_model src (.hclk, .hresetn, .load, .n_smp, .bad, .lcode,
		.rcode, .pk, .sch, .busy, .stb, .ok, .right, .bstart, .cs, .scheme,
		.aud, .fclk);
	always #25 hclk = ~hclk;
	// Keeps the last output sample and counts frame clock rises.
	always @(posedge hclk)
	begin
		if (audio_out_stb === 1'b1)
			last_aud <= audio_out;
		if (frame_clk_out === 1'b1 && fc_prev === 1'b0)
			n_fc <= n_fc + 1;
		fc_prev <= frame_clk_out;
	end
	// ==================================================================
	// Bus and stream tasks.
	task automatic bus(input logic w, input logic [15:0] idx,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {14'h0, idx, 2'b00};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask
	task automatic rc(input logic [15:0] idx, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, idx, 32'h0, x);
		`CHK(x, e)
	endtask
	// Sends k samples; the two extra edges let flags settle.
	task automatic send(input int k, input logic b);
		n_smp <= k[15:0];
		bad <= b;
		load <= 1'b1;
		@(posedge hclk);
		load <= 1'b0;
		do @(posedge hclk); while (busy);
		repeat (2) @(posedge hclk);
	endtask
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Cuts a hang short; the tests need about 16000 cycles.
	initial
	begin
		#3_000_000;
		n_mismatch++;
		test_done();
	end
	// ==================================================================
	// Test sequence.
	initial
	begin
		{hresetn, hsel, hwrite, load, bad, pk, sch} <= 7'h0;
		{haddr, hwdata, htrans, n_smp, lcode, rcode} <= 90'h0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rc(`SRX_IDX_LOCK, 32'h0);
		rc(`SRX_IDX_CTRL, 32'h0);
		rc(`SRX_IDX_DECODE, 32'h0);
		wr(`SRX_IDX_LOCK, 32'h1);
		rc(`SRX_IDX_LOCK, 32'h0);
		rc(16'h0123, 32'h0);
		wr(`SRX_IDX_IRQ_EN, 32'h7);
		send(63, 1'b0);
		rc(`SRX_IDX_LOCK, 32'h0);
		send(1, 1'b0);
		rc(`SRX_IDX_LOCK, 32'h1);
		rc(`SRX_IDX_IRQ_STAT, 32'h1);
		`CHK(irq, 1'b1)
		wr(`SRX_IDX_IRQ_CLR, 32'h7);
		rc(`SRX_IDX_IRQ_STAT, 32'h0);
		`CHK(irq, 1'b0)
		send(1, 1'b1);
		rc(`SRX_IDX_LOCK, 32'h0);
		rc(`SRX_IDX_IRQ_STAT, 32'h2);
		`CHK(irq, 1'b1)
		wr(`SRX_IDX_IRQ_EN, 32'h0);
		rc(`SRX_IDX_IRQ_EN, 32'h0);
		`CHK(irq, 1'b0)
		wr(`SRX_IDX_IRQ_CLR, 32'h7);
		wr(`SRX_IDX_CTRL, 32'h8);
		rc(`SRX_IDX_CTRL, 32'h8);
		send(7, 1'b0);
		rc(`SRX_IDX_LOCK, 32'h0);
		send(1, 1'b0);
		rc(`SRX_IDX_LOCK, 32'h1);
		n_fc = 0;
		send(20, 1'b1);
		`CHK(n_fc != 0, 1'b1)
		`CHK(last_aud, 24'h0)
		wr(`SRX_IDX_CTRL, 32'hC);
		send(8, 1'b0);
		n_fc = 0;
		send(20, 1'b1);
		`CHK(n_fc == 0, 1'b1)
		wr(`SRX_IDX_CTRL, 32'h8);
		for (int i = 0; i < 10; i++)
		begin
			lcode <= tbl[i];
			rcode <= tbl[(i + 3) % 10];
			pk <= i[0];
			sch <= i[1] & i[0];
			exp_dec = {22'h0, tbl[(i + 3) % 10], tbl[i], i[1] & i[0], i[0]};
			send(768, 1'b0);
			rc(`SRX_IDX_DECODE, exp_dec);
		end
		// Gain, loss and a change of decoded format have all been seen.
		rc(`SRX_IDX_IRQ_STAT, 32'h7);
		for (int w = 0; w < 4; w++)
		begin
			wr(`SRX_IDX_CTRL, {30'h2, w[1:0]});
			send(2, 1'b0);
			`CHK(last_aud, trunc[w])
		end
		test_done();
	end
endmodule
